// ---- hdl/tet_timer.sv ----
// ==========================================================
// What this block does
// R1 - Continuous mode: begin command arms for trigger stream
// R2 - Armed edge starts exposure of programmed length
// R3 - Exposure end starts frame readout
// R4 - End command disarms, triggers ignored
// R5 - Source triggers only while ready high
// R6 - Source stays within achievable frame rate
// R7 - Enabled rate limit below maximum caps trigger rate
// R8 - Limit above maximum: achievable rate governs
// R9 - Exposure clamped to model minimum and maximum
// R10 - Exposure equals multiplier times tick period
// R11 - Tick resets to 20 or 31 us
// R12 - Multiplier kept within 1 to 4095
// R13 - Tick steps 1 us or 31 us
// R14 - Multiplier 1 with maximal tick gives maximum
// R15 - Direct exposure set in whole microseconds
// R16 - Direct write derives and loads multiplier
// R17 - Direct value rounds to nearest tick multiple
// R18 - Multiplier change updates readable exposure
// R19 - Auto value free; unavailable in width mode
// R20 - Ready rises when safe, falls at start
// R21 - Edges while ready low are ignored
// R22 - Trigger polarity rising or falling selectable
// R23 - Trigger synchronised, one pulse per transition
`default_nettype none
module tet_timer
	import tet_pkg::*;
#(
	parameter bit REDUCED_RANGE = 1'b0,
	parameter int unsigned MIN_EXP_US = MIN_EXP_DEF_US
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [AXI_AW-1:0] i_axi_awaddr,
	input wire logic i_axi_awvalid,
	output logic o_axi_awready,
	input wire logic [31:0] i_axi_wdata,
	input wire logic [3:0] i_axi_wstrb,
	input wire logic i_axi_wvalid,
	output logic o_axi_wready,
	output logic [1:0] o_axi_bresp,
	output logic o_axi_bvalid,
	input wire logic i_axi_bready,
	input wire logic [AXI_AW-1:0] i_axi_araddr,
	input wire logic i_axi_arvalid,
	output logic o_axi_arready,
	output logic [31:0] o_axi_rdata,
	output logic [1:0] o_axi_rresp,
	output logic o_axi_rvalid,
	input wire logic i_axi_rready,
	input wire logic i_external_trigger_input,
	output logic o_trigger_ready_output,
	output logic o_readout_start
);
	// ==========================================================
	// Variant constants
	localparam int unsigned MAX_EXP_US = REDUCED_RANGE ? MAX_EXP_RED_US : MAX_EXP_STD_US;
	localparam logic [US_W-1:0] MAX_EXP = US_W'(MAX_EXP_US);
	localparam logic [US_W-1:0] MIN_EXP = US_W'(MIN_EXP_US);
	localparam logic [US_W-1:0] TICK_STEP = US_W'(REDUCED_RANGE ? TICK_STEP_RED_US : TICK_STEP_STD_US);
	localparam logic [US_W-1:0] TICK_DEF = US_W'(REDUCED_RANGE ? TICK_DEF_RED_US : TICK_DEF_STD_US); // [R11]
	localparam int unsigned DIV_W = $clog2(US_CYC);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(US_CYC - 1);
	localparam logic [31:0] CYC_PER_US = 32'(US_CYC);
	localparam logic [4:0] DV_LAST = 5'(DV_STEPS - 1);

	if (MIN_EXP_US < 1 || MIN_EXP_US > MAX_EXP_US || US_CYC < 2) begin : g_chk
		$error("tet_timer: unsupported exposure limits or clock rate");
	end

	typedef struct packed {
		tet_acq_e acq;
		logic armed;
		logic sync1;
		logic sync2;
		logic prev;
		logic [31:0] exp_left;
		logic [DIV_W-1:0] us_div;
		logic [US_W-1:0] rate_cnt;
		logic readout;
		tet_cfg_s cfg;
		logic dv_busy;
		logic [4:0] dv_cnt;
		logic [US_W+1:0] dv_rem;
		logic [US_W:0] dv_quo;
		logic aw_have;
		logic [AXI_AW-1:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tet_state_s;

	localparam tet_state_s ST_RST = '{
		acq: TET_IDLE,
		cfg: '{ctrl: CTRL_RST, mult: MULT_RST, tick: TICK_DEF, auto_us: '0, rate_us: '0},
		default: '0
	};

	// ==========================================================
	// Helpers
	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return m;
	endfunction : merge_strb

	function automatic logic addr_ok(input logic [AXI_AW-1:0] a);
		return a[1:0] == 2'h0 && a <= ADDR_STATUS;
	endfunction : addr_ok

	function automatic logic [US_W-1:0] clamp_exp(input logic [PROD_W-1:0] v);
		logic [US_W-1:0] r;
		if (v > PROD_W'(MAX_EXP)) begin
			r = MAX_EXP;
		end else if (v < PROD_W'(MIN_EXP)) begin
			r = MIN_EXP;
		end else begin
			r = v[US_W-1:0];
		end
		return r; // [R9]
	endfunction : clamp_exp

	function automatic logic [US_W-1:0] clip_us(input logic [31:0] v);
		return (v > 32'(MAX_EXP)) ? MAX_EXP : v[US_W-1:0];
	endfunction : clip_us

	tet_state_s q;
	tet_state_s d;
	logic trig_edge;
	logic rate_ok;
	logic trig_ready;
	logic acq_start;
	logic auto_sel;
	logic [PROD_W-1:0] prod;
	logic [US_W-1:0] exp_us;

	// ==========================================================
	// Exposure arithmetic
	assign prod = PROD_W'(q.cfg.mult) * PROD_W'(q.cfg.tick); // [R10] [R14]
	assign auto_sel = q.cfg.ctrl[CTRL_AUTO] && !q.cfg.ctrl[CTRL_WIDTH]; // [R19]
	assign exp_us = auto_sel ? clamp_exp(PROD_W'(q.cfg.auto_us)) : clamp_exp(prod); // [R9] [R18]

	// ==========================================================
	// Trigger qualification
	// Only the second stage and its delayed copy feed the edge detector.
	assign trig_edge = q.cfg.ctrl[CTRL_FALL] ? (q.prev && !q.sync2) : (!q.prev && q.sync2); // [R22] [R23]
	// A rate period beyond the achievable one just stretches the wait; below it, exposure end rules.
	assign rate_ok = !q.cfg.ctrl[CTRL_RATE_EN] || q.cfg.rate_us == '0 || q.rate_cnt >= q.cfg.rate_us; // [R7] [R8]
	assign trig_ready = q.armed && q.acq == TET_IDLE && rate_ok; // [R20]
	assign acq_start = trig_edge && trig_ready; // [R2] [R21]

	assign o_trigger_ready_output = trig_ready;
	assign o_readout_start = q.readout;
	assign o_axi_awready = !q.aw_have && !q.bvalid;
	assign o_axi_wready = !q.w_have && !q.bvalid;
	assign o_axi_bvalid = q.bvalid;
	assign o_axi_bresp = q.bresp;
	assign o_axi_arready = !q.rvalid;
	assign o_axi_rvalid = q.rvalid;
	assign o_axi_rdata = q.rdata;
	assign o_axi_rresp = q.rresp;

	// ==========================================================
	// Next state
	always_comb begin
		logic [31:0] wv;
		logic [US_W+1:0] rsh;
		logic [US_W:0] qsh;
		logic [US_W-1:0] tq;
		wv = '0;
		rsh = '0;
		qsh = '0;
		tq = '0;
		d = q;
		d.readout = 1'b0;
		d.sync1 = i_external_trigger_input;
		d.sync2 = q.sync1;
		d.prev = q.sync2;

		// Microsecond enable and frame rate counter
		if (q.us_div == DIV_LAST) begin
			d.us_div = '0;
			if (q.rate_cnt != '1) begin
				d.rate_cnt = q.rate_cnt + 1'b1;
			end
		end else begin
			d.us_div = q.us_div + 1'b1;
		end

		case (q.acq)
			TET_IDLE: begin
				if (acq_start) begin
					d.acq = TET_EXPOSE;
					d.exp_left = 32'(exp_us) * CYC_PER_US; // [R2]
					d.us_div = '0;
					d.rate_cnt = '0; // [R7]
					if (!q.cfg.ctrl[CTRL_CONT]) begin
						d.armed = 1'b0;
					end
				end
			end
			TET_EXPOSE: begin
				if (q.exp_left <= 32'h0000_0001) begin
					d.acq = TET_IDLE;
					d.readout = 1'b1; // [R3]
				end else begin
					d.exp_left = q.exp_left - 1'b1;
				end
			end
			default: begin
				d.acq = TET_IDLE;
			end
		endcase

		// Restoring divider: multiplier = round(duration / tick)
		if (q.dv_busy) begin
			rsh = {q.dv_rem[US_W:0], q.dv_quo[US_W]};
			qsh = {q.dv_quo[US_W-1:0], 1'b0};
			if (rsh >= (US_W+2)'(q.cfg.tick)) begin
				rsh = rsh - (US_W+2)'(q.cfg.tick);
				qsh[0] = 1'b1;
			end
			d.dv_rem = rsh;
			d.dv_quo = qsh;
			d.dv_cnt = q.dv_cnt + 1'b1;
			if (q.dv_cnt == DV_LAST) begin
				d.dv_busy = 1'b0;
				if (qsh < (US_W+1)'(MULT_MIN)) begin
					d.cfg.mult = MULT_MIN; // [R12]
				end else if (qsh > (US_W+1)'(MULT_MAX)) begin
					d.cfg.mult = MULT_MAX; // [R12]
				end else begin
					d.cfg.mult = qsh[MULT_W-1:0]; // [R16]
				end
			end
		end

		// Bus: write channels
		if (i_axi_awvalid && o_axi_awready) begin
			d.aw_have = 1'b1;
			d.aw_addr = i_axi_awaddr;
		end
		if (i_axi_wvalid && o_axi_wready) begin
			d.w_have = 1'b1;
			d.w_data = i_axi_wdata;
			d.w_strb = i_axi_wstrb;
		end
		if (q.bvalid && i_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_have && q.w_have) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = addr_ok(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			case (q.aw_addr)
				ADDR_CTRL: begin
					wv = merge_strb(32'(q.cfg.ctrl), q.w_data, q.w_strb);
					d.cfg.ctrl = wv[CTRL_W-1:0];
				end
				ADDR_CMD: begin
					wv = merge_strb('0, q.w_data, q.w_strb);
					if (wv[CMD_BEGIN]) begin
						d.armed = 1'b1; // [R1]
					end
					if (wv[CMD_END]) begin
						d.armed = 1'b0; // [R4]
					end
				end
				ADDR_MULT: begin
					wv = merge_strb(32'(q.cfg.mult), q.w_data, q.w_strb);
					d.dv_busy = 1'b0;
					if (wv < 32'(MULT_MIN)) begin
						d.cfg.mult = MULT_MIN; // [R12]
					end else if (wv > 32'(MULT_MAX)) begin
						d.cfg.mult = MULT_MAX; // [R12]
					end else begin
						d.cfg.mult = wv[MULT_W-1:0]; // [R18]
					end
				end
				ADDR_TICK: begin
					wv = merge_strb(32'(q.cfg.tick), q.w_data, q.w_strb);
					tq = clip_us(wv);
					tq = tq - (tq % TICK_STEP); // [R13]
					d.cfg.tick = (tq < TICK_STEP) ? TICK_STEP : tq;
					d.dv_busy = 1'b0;
				end
				ADDR_EXP: begin
					wv = merge_strb(32'(exp_us), q.w_data, q.w_strb);
					// Half a tick added first so truncating division gives the nearest multiple.
					d.dv_quo = (US_W+1)'(clip_us(wv)) + (US_W+1)'(q.cfg.tick >> 1); // [R15] [R17]
					d.dv_rem = '0;
					d.dv_cnt = '0;
					d.dv_busy = 1'b1; // [R16]
				end
				ADDR_AUTO: begin
					wv = merge_strb(32'(q.cfg.auto_us), q.w_data, q.w_strb);
					d.cfg.auto_us = clip_us(wv); // [R19]
				end
				ADDR_RATE: begin
					wv = merge_strb(32'(q.cfg.rate_us), q.w_data, q.w_strb);
					d.cfg.rate_us = clip_us(wv);
				end
				default: begin
					d.bresp = addr_ok(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
				end
			endcase
		end

		// Bus: read channel
		if (q.rvalid && i_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (i_axi_arvalid && o_axi_arready) begin
			d.rvalid = 1'b1;
			d.rresp = addr_ok(i_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (i_axi_araddr)
				ADDR_CTRL: d.rdata = 32'(q.cfg.ctrl);
				ADDR_MULT: d.rdata = 32'(q.cfg.mult);
				ADDR_TICK: d.rdata = 32'(q.cfg.tick);
				ADDR_EXP: d.rdata = 32'(exp_us); // [R18]
				ADDR_AUTO: d.rdata = 32'(q.cfg.auto_us);
				ADDR_RATE: d.rdata = 32'(q.cfg.rate_us);
				ADDR_STATUS: begin
					d.rdata = '0;
					d.rdata[ST_ARMED] = q.armed;
					d.rdata[ST_READY] = trig_ready;
					d.rdata[ST_EXPOSING] = q.acq == TET_EXPOSE;
					d.rdata[ST_DIV_BUSY] = q.dv_busy;
				end
				default: d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Checks
	logic [31:0] hlp_cyc;
	logic [31:0] hlp_need;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hlp_cyc <= '0;
			hlp_need <= '0;
		end else if (acq_start) begin
			// Counts the exposing cycles that precede the readout pulse
			hlp_cyc <= '0;
			hlp_need <= 32'(exp_us) * CYC_PER_US;
		end else if (q.acq == TET_EXPOSE) begin
			hlp_cyc <= hlp_cyc + 1'b1;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	exposure_length_a: assert property (o_readout_start |-> hlp_cyc == hlp_need) // [R2]
		else $error("exposure did not last the programmed cycles");
	readout_follows_a: assert property ($fell(q.acq == TET_EXPOSE) |-> o_readout_start) // [R3]
		else $error("readout did not start at exposure end");
	ignore_unready_a: assert property (trig_edge && !trig_ready |=> !(q.acq == TET_EXPOSE && $past(q.acq) == TET_IDLE)) // [R21]
		else $error("trigger accepted while not ready");
	ready_falls_a: assert property (acq_start |=> !o_trigger_ready_output && q.acq == TET_EXPOSE) // [R20]
		else $error("ready stayed high after start");
	capture_end_a: assert property (q.aw_have && q.w_have && q.aw_addr == ADDR_CMD
		&& q.w_strb[0] && q.w_data[CMD_END] |=> !q.armed [*2]) // [R4]
		else $error("still armed after capture end");
	rate_limit_a: assert property (acq_start && q.cfg.ctrl[CTRL_RATE_EN] && q.cfg.rate_us != '0
		|-> q.rate_cnt >= q.cfg.rate_us) // [R7]
		else $error("trigger accepted above the rate limit");
	mult_range_a: assert property (q.cfg.mult >= MULT_MIN && q.cfg.mult <= MULT_MAX) // [R12]
		else $error("multiplier out of range");
	exp_limit_a: assert property (exp_us >= MIN_EXP && exp_us <= MAX_EXP) // [R9]
		else $error("exposure outside its limits");
	tick_step_a: assert property (q.cfg.tick % TICK_STEP == '0 && q.cfg.tick != '0) // [R13]
		else $error("tick period off its step");
	one_pulse_a: assert property (trig_edge |=> !trig_edge) // [R23]
		else $error("one transition gave two pulses");
	exp_product_a: assert property (!auto_sel && prod <= PROD_W'(MAX_EXP)
		&& prod >= PROD_W'(MIN_EXP) |-> PROD_W'(exp_us) == prod) // [R10]
		else $error("exposure differs from multiplier times tick");
endmodule : tet_timer
`default_nettype wire

// ---- hdl/tet_pkg.sv ----
`default_nettype none
package tet_pkg;
	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam int unsigned AXI_AW = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_MULT = 8'h08;
	localparam logic [7:0] ADDR_TICK = 8'h0C;
	localparam logic [7:0] ADDR_EXP = 8'h10;
	localparam logic [7:0] ADDR_AUTO = 8'h14;
	localparam logic [7:0] ADDR_RATE = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	// ==========================================================
	// Field positions
	localparam int unsigned CTRL_W = 5;
	localparam int unsigned CTRL_CONT = 0;
	localparam int unsigned CTRL_FALL = 1;
	localparam int unsigned CTRL_RATE_EN = 2;
	localparam int unsigned CTRL_AUTO = 3;
	localparam int unsigned CTRL_WIDTH = 4;
	localparam int unsigned CMD_BEGIN = 0;
	localparam int unsigned CMD_END = 1;
	localparam int unsigned ST_ARMED = 0;
	localparam int unsigned ST_READY = 1;
	localparam int unsigned ST_EXPOSING = 2;
	localparam int unsigned ST_DIV_BUSY = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Reset values and exposure limits
	localparam int unsigned US_W = 24;
	localparam int unsigned MULT_W = 12;
	localparam int unsigned PROD_W = US_W + MULT_W;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h01;
	localparam logic [MULT_W-1:0] MULT_RST = 12'h064;
	localparam logic [MULT_W-1:0] MULT_MIN = 12'h001;
	localparam logic [MULT_W-1:0] MULT_MAX = 12'hFFF;
	localparam int unsigned MAX_EXP_STD_US = 10000000;
	localparam int unsigned MAX_EXP_RED_US = 126976;
	localparam int unsigned TICK_DEF_STD_US = 20;
	localparam int unsigned TICK_DEF_RED_US = 31;
	localparam int unsigned TICK_STEP_STD_US = 1;
	localparam int unsigned TICK_STEP_RED_US = 31;
	localparam int unsigned MIN_EXP_DEF_US = 100;
	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned HZ_PER_MHZ = 1000000;
	localparam int unsigned US_CYC = CLK_HZ / HZ_PER_MHZ;
	localparam int unsigned DV_STEPS = US_W + 1;

	typedef enum logic [0:0] {TET_IDLE, TET_EXPOSE} tet_acq_e;

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [MULT_W-1:0] mult;
		logic [US_W-1:0] tick;
		logic [US_W-1:0] auto_us;
		logic [US_W-1:0] rate_us;
	} tet_cfg_s;
endpackage : tet_pkg
`default_nettype wire

// ---- tb/tet_trig_src.sv ----
`default_nettype none
// ==========================================
// Trigger source: waits for ready unless told to force a pulse
module tet_trig_src (
	input wire logic i_clk,
	input wire logic i_fire,
	input wire logic i_force,
	input wire logic i_idle,
	input wire logic [7:0] i_delay,
	input wire logic i_ready,
	output logic o_trig
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_trig = 1'b0;
	always begin
		@(posedge i_clk);
		if (i_fire) begin
			repeat (i_delay) @(posedge i_clk);
			while (!i_force && i_ready !== 1'b1) @(posedge i_clk);
			o_trig <= !i_idle;
			// Held for several cycles so the synchroniser cannot miss it
			repeat (4) @(posedge i_clk);
			o_trig <= i_idle;
		end else begin
			o_trig <= i_idle;
		end
	end
endmodule : tet_trig_src
`default_nettype wire

// ---- tb/tet_timer_tb_top.sv ----
`default_nettype none
module tet_timer_tb_top
	import tet_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [7:0] delay = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic fire = 1'b0, frc = 1'b0, idle = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, trig, ready, ro;
	logic [1:0] bresp, rresp, lresp;
	logic [31:0] rdata, ldata;
	int miscompares = 0, checks = 0, cycles = 0;

	initial begin
		forever #20 clk = !clk;
	end

	tet_timer #(.REDUCED_RANGE(1'b0), .MIN_EXP_US(1)) DUT (
		.i_clk(clk), .i_rst_b(rst_b),
		.i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
		.i_axi_wdata(wdata), .i_axi_wstrb(4'hF), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
		.o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
		.i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
		.o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
		.i_external_trigger_input(trig), .o_trigger_ready_output(ready), .o_readout_start(ro)
	);
	tet_trig_src SRC (.i_clk(clk), .i_fire(fire), .i_force(frc), .i_idle(idle), .i_delay(delay),
		.i_ready(ready), .o_trig(trig));

	// ==========================================
	// Bus and trigger helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checks++;
		if (got !== want) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, want);
		end
	endtask : chk

	// Handshakes are judged on settled values half a cycle before the edge that takes them
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic aw_hs;
		logic w_hs;
		logic b_hs;
		n = 0;
		b_hs = 1'b0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_hs && n < 50) begin
			@(negedge clk);
			aw_hs = awvalid && awready === 1'b1;
			w_hs = wvalid && wready === 1'b1;
			b_hs = bvalid === 1'b1;
			if (b_hs) begin
				lresp = bresp;
			end
			@(posedge clk);
			n++;
			if (aw_hs) begin
				awvalid <= 1'b0;
			end
			if (w_hs) begin
				wvalid <= 1'b0;
			end
		end
		chk(b_hs, 1'b1);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		logic ar_hs;
		logic r_hs;
		n = 0;
		r_hs = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_hs && n < 50) begin
			@(negedge clk);
			ar_hs = arvalid && arready === 1'b1;
			r_hs = rvalid === 1'b1;
			if (r_hs) begin
				ldata = rdata;
				lresp = rresp;
			end
			@(posedge clk);
			n++;
			if (ar_hs) begin
				arvalid <= 1'b0;
			end
		end
		chk(r_hs, 1'b1);
		rready <= 1'b0;
	endtask : rd

	task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
		rd(a);
		chk(ldata, want);
	endtask : rdchk

	// Divider result is only readable once the busy flag drops
	task automatic direct(input logic [31:0] w, input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		wr(ADDR_EXP, w);
		ldata = 32'h00000008;
		while (ldata[ST_DIV_BUSY] !== 1'b0 && n < 20) begin
			rd(ADDR_STATUS);
			n++;
		end
		rdchk(ADDR_MULT, m);
		rdchk(ADDR_EXP, e);
	endtask : direct

	task automatic pulse(input logic f);
		@(posedge clk);
		frc <= f;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask : pulse

	task automatic wait_rdy(input logic lvl);
		int n;
		n = 0;
		while (ready !== lvl && n < 2000) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_rdy

	// Cycles from acceptance to readout, then to ready rising again
	task automatic acq(input int n, input int lo, input int hi);
		int c;
		c = 0;
		wait_rdy(1'b1);
		pulse(1'b0);
		wait_rdy(1'b0);
		while (ro !== 1'b1 && c < 2000) begin
			@(negedge clk);
			c++;
		end
		chk(c, n);
		while (ready !== 1'b1 && c < 2000) begin
			@(negedge clk);
			c++;
		end
		chk(c >= lo && c <= hi, 32'h00000001);
	endtask : acq

	task automatic count_ro(input int cyc, output int k);
		k = 0;
		repeat (cyc) begin
			@(negedge clk);
			if (ro === 1'b1) begin
				k++;
			end
		end
	endtask : count_ro

	// ==========================================
	// Scenarios
	task automatic t_regs();
		rdchk(ADDR_CTRL, 32'h00000001);
		rdchk(ADDR_TICK, 32'h00000014);
		rdchk(ADDR_EXP, 32'h000007D0);
		rd(8'h20);
		chk(lresp, RESP_SLVERR);
		wr(ADDR_MULT, 32'h00000004);
		chk(lresp, RESP_OKAY);
		wr(8'h20, 32'h00000001);
		chk(lresp, RESP_SLVERR);
		wr(ADDR_TICK, 32'h00000001);
		rdchk(ADDR_EXP, 32'h00000004);
		wr(ADDR_MULT, 32'h00000000);
		rdchk(ADDR_MULT, 32'h00000001);
		wr(ADDR_MULT, 32'h00001000);
		rdchk(ADDR_EXP, 32'h00000FFF);
		wr(ADDR_TICK, 32'h00000007);
		wr(ADDR_MULT, 32'h00000003);
		rdchk(ADDR_TICK, 32'h00000007);
		rdchk(ADDR_EXP, 32'h00000015);
		wr(ADDR_TICK, 32'h00989680);
		wr(ADDR_MULT, 32'h00000001);
		rdchk(ADDR_EXP, 32'h00989680);
		wr(ADDR_MULT, 32'h00000002);
		rdchk(ADDR_EXP, 32'h00989680);
		wr(ADDR_TICK, 32'h00000014);
		direct(32'h00000081, 32'h00000006, 32'h00000078);
		direct(32'h00000097, 32'h00000008, 32'h000000A0);
		$display("register test done");
	endtask : t_regs

	task automatic t_trig();
		int k;
		wr(ADDR_MULT, 32'h00000004);
		wr(ADDR_TICK, 32'h00000001);
		@(negedge clk);
		chk(ready, 1'b0);
		wr(ADDR_CMD, 32'h00000001);
		acq(100, 100, 103);
		pulse(1'b0);
		wait_rdy(1'b0);
		repeat (10) @(posedge clk);
		pulse(1'b1);
		count_ro(300, k);
		chk(k, 1);
		acq(100, 100, 103);
		wr(ADDR_CMD, 32'h00000002);
		@(negedge clk);
		chk(ready, 1'b0);
		pulse(1'b1);
		count_ro(200, k);
		chk(k, 0);
		wr(ADDR_CTRL, 32'h00000003);
		idle <= 1'b1;
		wr(ADDR_CMD, 32'h00000001);
		acq(100, 100, 103);
		wr(ADDR_CMD, 32'h00000002);
		idle <= 1'b0;
		// Single frame: the accepted trigger disarms, so ready stays low afterwards
		wr(ADDR_CTRL, 32'h00000000);
		wr(ADDR_CMD, 32'h00000001);
		wait_rdy(1'b1);
		pulse(1'b0);
		count_ro(200, k);
		chk(k, 1);
		chk(ready, 1'b0);
		wr(ADDR_CTRL, 32'h00000001);
		$display("trigger test done");
	endtask : t_trig

	task automatic t_rate();
		wr(ADDR_CTRL, 32'h00000005);
		wr(ADDR_RATE, 32'h0000000A);
		wr(ADDR_CMD, 32'h00000001);
		acq(100, 230, 275);
		delay <= 8'h09;
		acq(100, 230, 275);
		delay <= 8'h00;
		wr(ADDR_RATE, 32'h00000002);
		acq(100, 100, 103);
		wr(ADDR_TICK, 32'h00000002);
		wr(ADDR_MULT, 32'h00000002);
		wr(ADDR_AUTO, 32'h00000007);
		wr(ADDR_CTRL, 32'h00000009);
		acq(175, 175, 178);
		wr(ADDR_CTRL, 32'h00000019);
		acq(100, 100, 103);
		$display("rate and auto test done");
	endtask : t_rate

	task automatic finish_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_trig();
		t_rate();
		finish_test();
	end
endmodule : tet_timer_tb_top
`default_nettype wire
